// >>> core/csmr_pkg.sv
// shared constants for the clock source and supply monitor registers
package csmr_pkg;
    // register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [7:0] ADDR_CRYSTAL_CFG = 8'he1;
    localparam logic [7:0] ADDR_CLK_CTRL2 = 8'he2;
    localparam logic [7:0] ADDR_SUPPLY_CTRL = 8'he3;
    localparam logic [7:0] ADDR_SUPPLY_STAT = 8'he4;
    localparam logic [7:0] ADDR_MAIN_TRIM = 8'he8;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'hf0;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'hf1;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hf2;
    // crystal configuration fields
    localparam int CRY_PRESENT_BIT = 0;
    localparam int CRY_WRITTEN_BIT = 1;
    localparam int CRY_LOW_POWER_BIT = 2;
    // clock control two fields
    localparam int CLK_EXT_MODE_BIT = 2;
    localparam int CLK_HS_EN_BIT = 4;
    // supply monitor control fields
    localparam int SUP_LEVEL_LSB = 0;
    localparam int SUP_LEVEL_MSB = 2;
    localparam int SUP_SPEED_RST_BIT = 3;
    localparam int SUP_POR_LSB = 4;
    localparam int SUP_POR_MSB = 5;
    // supply monitor status fields
    localparam int STAT_COMPARATOR_BIT = 1;
    // interrupt event bits
    localparam int IRQ_LV_BELOW = 0;
    localparam int IRQ_LV_ABOVE = 1;
    localparam int IRQ_CRY_LOCKED = 2;
    localparam int IRQ_COUNT = 3;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_POR_LEVEL = 2'h0;
    localparam logic [2:0] RST_LV_LEVEL = 3'h0;
    // crystal configuration lock state
    typedef enum logic {
        LOCK_OPEN,
        LOCK_SHUT
    } csmr_lock_e;
endpackage

// >>> core/csmr_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; output follows once stages two and three agree
module csmr_sync
    import csmr_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // asynchronous level in, clean level out
    input wire logic async_in,
    output logic sync_out
);
    logic stage1; // first stage, read only by stage2
    logic stage2; // second stage
    logic stage3; // third stage
    logic next_out; // next filtered output

    // output only moves when the last two stages agree
    always_comb begin
        next_out = sync_out;
        if (stage2 == stage3) begin
            next_out = stage3;
        end
    end

    // shift chain and filtered output
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            sync_out <= next_out;
        end
    end
endmodule
`default_nettype wire

// >>> core/csmr_irq.sv
`timescale 1ns/1ps
`default_nettype none
// sticky event status, write-one-to-clear, enable mask and level interrupt
module csmr_irq
    import csmr_pkg::*;
#(
    parameter int N = IRQ_COUNT
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // event pulses and register writes
    input wire logic [N-1:0] event_set,
    input wire logic clear_write,
    input wire logic enable_write,
    input wire logic [N-1:0] wdata,
    // state back to the register file and out
    output logic [N-1:0] status,
    output logic [N-1:0] enable,
    output logic irq
);
    logic [N-1:0] next_status; // next sticky state
    logic [N-1:0] next_enable; // next mask
    logic next_irq; // next interrupt level

    // a set in the clearing cycle wins over the clear
    always_comb begin
        next_status = status;
        if (clear_write) begin
            next_status = status & ~wdata;
        end
        next_status = next_status | event_set;
        next_enable = enable_write ? wdata : enable;
        next_irq = |(next_status & next_enable);
    end

    // register the interrupt state
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            status <= '0;
            enable <= '0;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            enable <= next_enable;
            irq <= next_irq;
        end
    end
endmodule
`default_nettype wire

// >>> core/csmr_top.sv
`timescale 1ns/1ps
`default_nettype none
module csmr_top
    import csmr_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    // analog comparator and clock requests
    input wire logic low_voltage_comparator,
    input wire logic slow_src_request_crystal,
    input wire logic ext_clock_pin_select,
    // crystal oscillator controls
    output logic crystal_low_power,
    output logic crystal_present,
    output logic slow_clk_use_crystal,
    // clock source controls
    output logic high_speed_clock_enable,
    output logic external_clock_mode,
    output logic ext_clock_use_alt_pin,
    // supply monitor controls
    output logic [1:0] power_on_trip_level,
    output logic [2:0] low_voltage_level,
    output logic speed_reg_reset,
    // main oscillator trim
    output logic [7:0] main_osc_trim,
    // interrupt
    output logic irq
);
    // address match, used by every decode
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] target);
        hit = (addr == target);
    endfunction

    // crystal configuration state
    csmr_lock_e lock_state; // open until first write
    csmr_lock_e next_lock_state; // next lock state
    logic crystal_written; // read-only written flag
    logic next_crystal_written; // next written flag
    logic next_crystal_low_power; // next low power bit
    logic next_crystal_present; // next present bit
    logic next_slow_clk_use_crystal; // next slow source

    // clock control two state
    logic next_high_speed_clock_enable; // next 48 MHz enable
    logic next_external_clock_mode; // next external mode
    logic next_ext_clock_use_alt_pin; // next pin choice

    // supply monitor state
    logic [1:0] next_power_on_trip_level; // next trip level
    logic [2:0] next_low_voltage_level; // next detect level
    logic speed_reset_enable; // speed reset on low voltage
    logic next_speed_reset_enable; // next speed reset enable
    logic next_speed_reg_reset; // next speed reset output
    logic lv_stable; // synchronised comparator
    logic lv_prev; // comparator one cycle ago
    logic next_lv_prev; // next previous value

    // trim and read path
    logic [7:0] next_main_osc_trim; // next trim
    logic [DATA_W-1:0] next_reg_rdata; // next read data

    // interrupt wiring
    logic [IRQ_COUNT-1:0] irq_events; // event pulses
    logic [IRQ_COUNT-1:0] irq_status; // sticky status
    logic [IRQ_COUNT-1:0] irq_enable; // enable mask
    logic irq_clear_write; // clear register write
    logic irq_enable_write; // enable register write

    // comparator crosses in from the analog side
    csmr_sync u_lv_sync (
        .core_clk(core_clk),
        .reset(reset),
        .async_in(low_voltage_comparator),
        .sync_out(lv_stable)
    );

    // sticky events with mask and level output
    csmr_irq #(
        .N(IRQ_COUNT)
    ) u_irq (
        .core_clk(core_clk),
        .reset(reset),
        .event_set(irq_events),
        .clear_write(irq_clear_write),
        .enable_write(irq_enable_write),
        .wdata(reg_wdata[IRQ_COUNT-1:0]),
        .status(irq_status),
        .enable(irq_enable),
        .irq(irq)
    );

    // next values for all control registers and the read path
    always_comb begin
        // hold by default; read data, events and write strobes default to zero
        next_lock_state = lock_state;
        next_crystal_written = crystal_written;
        next_crystal_low_power = crystal_low_power;
        next_crystal_present = crystal_present;
        next_high_speed_clock_enable = high_speed_clock_enable;
        next_external_clock_mode = external_clock_mode;
        next_power_on_trip_level = power_on_trip_level;
        next_low_voltage_level = low_voltage_level;
        next_speed_reset_enable = speed_reset_enable;
        next_main_osc_trim = main_osc_trim;
        next_reg_rdata = RST_BYTE;
        irq_events = '0;
        irq_clear_write = 1'b0;
        irq_enable_write = 1'b0;

        // crystal register: first write stores and locks
        case (lock_state)
            LOCK_OPEN: begin
                if (reg_write && hit(reg_addr, ADDR_CRYSTAL_CFG)) begin
                    next_crystal_low_power = reg_wdata[CRY_LOW_POWER_BIT];
                    next_crystal_present = reg_wdata[CRY_PRESENT_BIT];
                    next_crystal_written = 1'b1;
                    next_lock_state = LOCK_SHUT;
                    irq_events[IRQ_CRY_LOCKED] = 1'b1;
                end
            end
            LOCK_SHUT: begin
                next_lock_state = LOCK_SHUT;
            end
            default: begin
                next_lock_state = LOCK_OPEN;
            end
        endcase

        // write decode for the other registers
        if (reg_write) begin
            if (hit(reg_addr, ADDR_CLK_CTRL2)) begin
                next_high_speed_clock_enable = reg_wdata[CLK_HS_EN_BIT];
                next_external_clock_mode = reg_wdata[CLK_EXT_MODE_BIT];
            end else if (hit(reg_addr, ADDR_SUPPLY_CTRL)) begin
                next_power_on_trip_level = reg_wdata[SUP_POR_MSB:SUP_POR_LSB];
                next_speed_reset_enable = reg_wdata[SUP_SPEED_RST_BIT];
                next_low_voltage_level = reg_wdata[SUP_LEVEL_MSB:SUP_LEVEL_LSB];
            end else if (hit(reg_addr, ADDR_MAIN_TRIM)) begin
                next_main_osc_trim = reg_wdata;
            end else if (hit(reg_addr, ADDR_IRQ_CLEAR)) begin
                // clear sticky bits by writing ones
                irq_clear_write = 1'b1;
            end else if (hit(reg_addr, ADDR_IRQ_ENABLE)) begin
                // new interrupt mask
                irq_enable_write = 1'b1;
            end
        end

        // read decode; unmapped and reserved bits read zero
        if (reg_read) begin
            if (hit(reg_addr, ADDR_CRYSTAL_CFG)) begin
                next_reg_rdata[CRY_LOW_POWER_BIT] = crystal_low_power;
                next_reg_rdata[CRY_WRITTEN_BIT] = crystal_written;
                next_reg_rdata[CRY_PRESENT_BIT] = crystal_present;
            end else if (hit(reg_addr, ADDR_CLK_CTRL2)) begin
                next_reg_rdata[CLK_HS_EN_BIT] = high_speed_clock_enable;
                next_reg_rdata[CLK_EXT_MODE_BIT] = external_clock_mode;
            end else if (hit(reg_addr, ADDR_SUPPLY_CTRL)) begin
                next_reg_rdata[SUP_POR_MSB:SUP_POR_LSB] = power_on_trip_level;
                next_reg_rdata[SUP_SPEED_RST_BIT] = speed_reset_enable;
                next_reg_rdata[SUP_LEVEL_MSB:SUP_LEVEL_LSB] = low_voltage_level;
            end else if (hit(reg_addr, ADDR_SUPPLY_STAT)) begin
                next_reg_rdata[STAT_COMPARATOR_BIT] = lv_stable;
            end else if (hit(reg_addr, ADDR_MAIN_TRIM)) begin
                next_reg_rdata = main_osc_trim;
            end else if (hit(reg_addr, ADDR_IRQ_STATUS)) begin
                next_reg_rdata[IRQ_COUNT-1:0] = irq_status;
            end else if (hit(reg_addr, ADDR_IRQ_ENABLE)) begin
                next_reg_rdata[IRQ_COUNT-1:0] = irq_enable;
            end
        end

        next_slow_clk_use_crystal = slow_src_request_crystal & crystal_present;

        // pin choice only matters in external mode
        next_ext_clock_use_alt_pin = ext_clock_pin_select & external_clock_mode;

        next_speed_reg_reset = speed_reset_enable & lv_stable;

        // comparator edges become events
        next_lv_prev = lv_stable;
        irq_events[IRQ_LV_BELOW] = lv_stable & ~lv_prev;
        irq_events[IRQ_LV_ABOVE] = ~lv_stable & lv_prev;
    end

    // register all control state
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            lock_state <= LOCK_OPEN;
            crystal_written <= 1'b0;
            crystal_low_power <= 1'b0;
            crystal_present <= 1'b0;
            slow_clk_use_crystal <= 1'b0;
            high_speed_clock_enable <= 1'b0;
            external_clock_mode <= 1'b0;
            ext_clock_use_alt_pin <= 1'b0;
            power_on_trip_level <= RST_POR_LEVEL;
            low_voltage_level <= RST_LV_LEVEL;
            speed_reset_enable <= 1'b0;
            speed_reg_reset <= 1'b0;
            lv_prev <= 1'b0;
            main_osc_trim <= RST_BYTE;
            reg_rdata <= RST_BYTE;
        end else begin
            lock_state <= next_lock_state;
            crystal_written <= next_crystal_written;
            crystal_low_power <= next_crystal_low_power;
            crystal_present <= next_crystal_present;
            slow_clk_use_crystal <= next_slow_clk_use_crystal;
            high_speed_clock_enable <= next_high_speed_clock_enable;
            external_clock_mode <= next_external_clock_mode;
            ext_clock_use_alt_pin <= next_ext_clock_use_alt_pin;
            power_on_trip_level <= next_power_on_trip_level;
            low_voltage_level <= next_low_voltage_level;
            speed_reset_enable <= next_speed_reset_enable;
            speed_reg_reset <= next_speed_reg_reset;
            lv_prev <= next_lv_prev;
            main_osc_trim <= next_main_osc_trim;
            reg_rdata <= next_reg_rdata;
        end
    end

    // checks on the register behaviour
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    AST_LOW_POWER_STORE: assert property (
        (reg_write && hit(reg_addr, ADDR_CRYSTAL_CFG) && lock_state == LOCK_OPEN)
        |=> crystal_low_power == $past(reg_wdata[CRY_LOW_POWER_BIT]))
        else $error("crystal low power bit not stored");

    AST_WRITE_LOCKS: assert property (
        (reg_write && hit(reg_addr, ADDR_CRYSTAL_CFG))
        |=> crystal_written && lock_state == LOCK_SHUT)
        else $error("crystal write did not set flag and lock");

    AST_FLAG_CAUSE: assert property (
        $rose(crystal_written) |-> $past(reg_write) && $past(reg_addr) == ADDR_CRYSTAL_CFG)
        else $error("written flag rose without a write");

    AST_NO_SWITCH: assert property (
        !crystal_present |=> !slow_clk_use_crystal)
        else $error("crystal selected while absent");

    AST_FREE_SELECT: assert property (
        crystal_present |=> slow_clk_use_crystal == $past(slow_src_request_crystal))
        else $error("slow source did not follow request");

    AST_HS_ENABLE: assert property (
        (reg_write && hit(reg_addr, ADDR_CLK_CTRL2))
        |=> high_speed_clock_enable == $past(reg_wdata[CLK_HS_EN_BIT]))
        else $error("high speed enable not stored");

    AST_EXT_MODE: assert property (
        !external_clock_mode |=> !ext_clock_use_alt_pin)
        else $error("pin choice active outside external mode");

    AST_POR_LEVEL: assert property (
        (reg_write && hit(reg_addr, ADDR_SUPPLY_CTRL))
        |=> power_on_trip_level == $past(reg_wdata[SUP_POR_MSB:SUP_POR_LSB]))
        else $error("trip level not stored");

    AST_SPEED_RESET: assert property (
        (speed_reset_enable && lv_stable) [*2] |-> speed_reg_reset)
        else $error("speed reset missing under low voltage");

    AST_LV_LEVEL: assert property (
        (reg_write && hit(reg_addr, ADDR_SUPPLY_CTRL))
        |=> low_voltage_level == $past(reg_wdata[SUP_LEVEL_MSB:SUP_LEVEL_LSB]))
        else $error("detect level not stored");

    AST_STATUS_LIVE: assert property (
        (reg_read && hit(reg_addr, ADDR_SUPPLY_STAT))
        |=> reg_rdata[STAT_COMPARATOR_BIT] == $past(lv_stable))
        else $error("status does not show comparator");

    AST_TRIM_STORE: assert property (
        (reg_write && hit(reg_addr, ADDR_MAIN_TRIM)) |=> main_osc_trim == $past(reg_wdata))
        else $error("trim not stored");

    AST_LOCK_HOLDS: assert property (
        (lock_state == LOCK_SHUT) |=> $stable(crystal_present) && $stable(crystal_low_power))
        else $error("locked crystal register changed");

    AST_FLAG_READ: assert property (
        (reg_read && hit(reg_addr, ADDR_CRYSTAL_CFG))
        |=> reg_rdata[CRY_WRITTEN_BIT] == $past(crystal_written))
        else $error("written flag does not read back");

    AST_PRESENT_STORE: assert property (
        (reg_write && hit(reg_addr, ADDR_CRYSTAL_CFG) && lock_state == LOCK_OPEN)
        |=> crystal_present == $past(reg_wdata[CRY_PRESENT_BIT]))
        else $error("crystal present bit not stored");

    AST_EXT_MODE_STORE: assert property (
        (reg_write && hit(reg_addr, ADDR_CLK_CTRL2))
        |=> external_clock_mode == $past(reg_wdata[CLK_EXT_MODE_BIT]))
        else $error("external clock mode not stored");

    AST_SPEED_IDLE: assert property (
        !speed_reset_enable |=> !speed_reg_reset)
        else $error("speed reset without enable");

    AST_LOCKED_WRITE: assert property (
        (reg_write && hit(reg_addr, ADDR_CRYSTAL_CFG) && lock_state == LOCK_SHUT)
        |=> crystal_present == $past(crystal_present))
        else $error("locked crystal write took effect");
endmodule
`default_nettype wire

// >>> verification/csmr_xtal_model.sv
`timescale 1ns/1ps
`default_nettype none
// crystal seen from outside: drive level and whether it feeds the slow net
module csmr_xtal_model (
    // controls from the block
    input wire logic crystal_low_power,
    input wire logic crystal_present,
    input wire logic slow_clk_use_crystal,
    // modelled crystal state
    output logic [1:0] drive_level,
    output logic feeding
);
    assign drive_level = crystal_low_power ? 2'h1 : 2'h3;
    assign feeding = slow_clk_use_crystal & crystal_present;
endmodule
`default_nettype wire

// >>> verification/tb_csmr_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
    $display("BAD %0t %h %h", $time, a, b); end end
module tb_csmr_top;
    import csmr_pkg::*;
    // clock, reset and register port
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    // side inputs
    logic lvc = 1'b0;
    logic slow_req = 1'b0;
    logic pin_sel = 1'b0;
    // outputs
    logic cry_lp, cry_pr, slow_use, hs_en, ext_mode, alt_pin, spd_rst, irq;
    logic [1:0] por_lvl, drive_level;
    logic [2:0] lv_lvl;
    logic [7:0] trim;
    logic feeding;
    // bookkeeping
    int err_count = 0;
    int num_checks = 0;
    int seed = 32'h1796;
    logic [7:0] v;
    // main oscillator range, kept by firmware outside the block
    logic [1:0] osc_range = 2'h1;
    logic [7:0] unmapped [8] = '{8'he1, 8'he2, 8'he3, 8'he4, 8'he8, 8'hf0, 8'hf2, 8'he5};

    // free-running clock
    always #20 core_clk = ~core_clk;

    csmr_top dut (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .low_voltage_comparator(lvc), .slow_src_request_crystal(slow_req),
        .ext_clock_pin_select(pin_sel), .crystal_low_power(cry_lp), .crystal_present(cry_pr),
        .slow_clk_use_crystal(slow_use), .high_speed_clock_enable(hs_en),
        .external_clock_mode(ext_mode), .ext_clock_use_alt_pin(alt_pin),
        .power_on_trip_level(por_lvl), .low_voltage_level(lv_lvl), .speed_reg_reset(spd_rst),
        .main_osc_trim(trim), .irq(irq)
    );

    csmr_xtal_model xtal (
        .crystal_low_power(cry_lp), .crystal_present(cry_pr), .slow_clk_use_crystal(slow_use),
        .drive_level(drive_level), .feeding(feeding)
    );

    // expected readback of clock control two
    function automatic logic [7:0] exp_clk2(input logic [7:0] d);
        return d & 8'h14;
    endfunction

    // expected readback of supply monitor control
    function automatic logic [7:0] exp_sup(input logic [7:0] d);
        return d & 8'h3f;
    endfunction

    // trim looked up per range, as a table read would
    function automatic logic [7:0] trim_for(input logic [1:0] r);
        return {r, r, 4'h9};
    endfunction

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
        #1;
    endtask

    // one-cycle read strobe, data checked in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    // let a number of edges pass, then settle
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // verdict and end of run
    task automatic stop_test;
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        stop_test();
    end

    // main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        // reset values, unmapped offset last
        for (int i = 0; i < 8; i++) begin
            rd(unmapped[i], 8'h00);
        end
        // crystal request while not fitted
        @(posedge core_clk);
        slow_req <= 1'b1;
        wait_cyc(2);
        `CHK(slow_use, 1'b0)
        // random clock, supply and trim settings
        for (int i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            @(posedge core_clk);
            pin_sel <= v[0];
            wr(ADDR_CLK_CTRL2, v & 8'h14);
            wait_cyc(1);
            `CHK(hs_en, v[4])
            `CHK(ext_mode, v[2])
            `CHK(alt_pin, v[2] & v[0])
            rd(ADDR_CLK_CTRL2, exp_clk2(v));
            wr(ADDR_SUPPLY_CTRL, v & 8'h37);
            `CHK(por_lvl, v[5:4])
            rd(ADDR_SUPPLY_CTRL, exp_sup(v & 8'h37));
            wr(ADDR_MAIN_TRIM, v);
            `CHK(trim, v)
            rd(ADDR_MAIN_TRIM, v);
        end
        // every detect level
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_SUPPLY_CTRL, 8'(i));
            `CHK(lv_lvl, 3'(i))
        end
        // range up: trim then range; range down: range then trim
        wr(ADDR_MAIN_TRIM, trim_for(2'h3));
        osc_range = 2'h3;
        `CHK(trim, trim_for(osc_range))
        osc_range = 2'h0;
        wr(ADDR_MAIN_TRIM, trim_for(osc_range));
        `CHK(trim, trim_for(osc_range))
        // first crystal write: fitted, low power, then locked
        wr(ADDR_CRYSTAL_CFG, 8'h05);
        wait_cyc(1);
        `CHK(cry_pr, 1'b1)
        `CHK(drive_level, 2'h1)
        `CHK(feeding, 1'b1)
        rd(ADDR_CRYSTAL_CFG, 8'h07);
        wr(ADDR_CRYSTAL_CFG, 8'h00);
        rd(ADDR_CRYSTAL_CFG, 8'h07);
        `CHK(cry_lp, 1'b1)
        @(posedge core_clk);
        slow_req <= 1'b0;
        wait_cyc(2);
        `CHK(slow_use, 1'b0)
        // lock event raises, is masked, then cleared
        rd(ADDR_IRQ_STATUS, 8'h04);
        `CHK(irq, 1'b0)
        wr(ADDR_IRQ_ENABLE, 8'h07);
        wait_cyc(1);
        `CHK(irq, 1'b1)
        wr(ADDR_IRQ_CLEAR, 8'h04);
        wait_cyc(1);
        `CHK(irq, 1'b0)
        // supply drops with speed reset enabled
        wr(ADDR_SUPPLY_CTRL, 8'h08);
        @(posedge core_clk);
        lvc <= 1'b1;
        wait_cyc(8);
        `CHK(spd_rst, 1'b1)
        `CHK(irq, 1'b1)
        rd(ADDR_SUPPLY_STAT, 8'h02);
        rd(ADDR_IRQ_STATUS, 8'h01);
        // supply recovers
        @(posedge core_clk);
        lvc <= 1'b0;
        wait_cyc(8);
        `CHK(spd_rst, 1'b0)
        rd(ADDR_SUPPLY_STAT, 8'h00);
        rd(ADDR_IRQ_STATUS, 8'h03);
        wr(ADDR_IRQ_CLEAR, 8'h03);
        rd(ADDR_IRQ_STATUS, 8'h00);
        // below with speed reset disabled
        wr(ADDR_SUPPLY_CTRL, 8'h00);
        @(posedge core_clk);
        lvc <= 1'b1;
        wait_cyc(8);
        `CHK(spd_rst, 1'b0)
        // second reset opens the lock again
        @(posedge core_clk);
        lvc <= 1'b0;
        reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        rd(ADDR_CRYSTAL_CFG, 8'h00);
        `CHK(irq, 1'b0)
        wr(ADDR_CRYSTAL_CFG, 8'h01);
        rd(ADDR_CRYSTAL_CFG, 8'h03);
        stop_test();
    end
endmodule
`default_nettype wire
